// File: hw/ppwm_pin_ctrl.v
// pin-control logic: can-port pulls and open-drain, shared-port muxing
`timescale 1ns/1ps
`include "ppwm_defs.vh"
module ppwm_pin_ctrl (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // shared port pins
    input wire [5:0] shared_port_pin_in,
    output reg [5:0] shared_port_pin_out,
    output reg [5:0] shared_port_pin_oe,
    // pwm
    input wire [5:0] pwm_enable,
    input wire [5:0] pwm_out,
    input wire pwm_shutdown_en,
    // serial b and i2c
    input wire serial_b_tx_enable,
    input wire serial_b_rx_enable,
    input wire serial_b_transmit,
    output reg serial_b_receive,
    input wire i2c_enable,
    input wire i2c_scl_out,
    input wire i2c_sda_out,
    output reg i2c_scl_in,
    output reg i2c_sda_in,
    // can controllers: index 0 is can a on pins 3/2, 1 is can b on 5/4
    input wire [1:0] can_enable,
    input wire [1:0] can_transmit,
    output reg [1:0] can_receive,
    // can port pins and pull devices
    input wire [7:0] can_port_pin_in,
    output reg [7:0] can_port_pin_out,
    output reg [7:0] can_port_pin_oe,
    output reg [7:0] can_port_pullup_on,
    output reg [7:0] can_port_pulldown_on
);
    localparam PW = `PPWM_P_WIDTH;
    localparam MW = `PPWM_M_WIDTH;

    reg [PW-1:0] shared_port_data_ff;
    reg [PW-1:0] shared_port_direction_ff;
    reg [MW-1:0] can_port_pull_enable_ff;
    reg [MW-1:0] can_port_pull_polarity_ff;
    reg [MW-1:0] can_port_open_drain_select_ff;
    reg [MW-1:0] can_port_direction_ff;
    reg [MW-1:0] can_port_data_ff;

    // apb access phase completes in its second cycle, after one wait state
    wire acc = psel & penable;
    wire wr = acc & pwrite;

    // decoded offsets; anything else is refused
    function known_addr;
        input [11:0] a;
        begin
            known_addr = (a == `PPWM_OFF_DATA) || (a == `PPWM_OFF_LEVELS) ||
                (a == `PPWM_OFF_DIR) || (a == `PPWM_OFF_CAN_PULL_EN) ||
                (a == `PPWM_OFF_CAN_POL) || (a == `PPWM_OFF_CAN_OD) ||
                (a == `PPWM_OFF_CAN_DIR) || (a == `PPWM_OFF_CAN_DATA);
        end
    endfunction

    // output bits read back the latch, input bits the live pad
    function [MW-1:0] read_back;
        input [MW-1:0] dir;
        input [MW-1:0] latch;
        input [MW-1:0] pin;
        begin
            read_back = (dir & latch) | (~dir & pin);
        end
    endfunction

    // shared-port ownership
    reg [PW-1:0] p_own_out;
    reg [PW-1:0] p_own_in;
    reg [PW-1:0] p_od;
    reg [PW-1:0] p_val;
    reg [PW-1:0] p_gpio;
    reg [PW-1:0] nxt_p_out;
    reg [PW-1:0] nxt_p_oe;
    reg i2c_own;
    integer i;
    always @* begin
        p_own_out = {PW{1'b0}};
        p_own_in = {PW{1'b0}};
        p_od = {PW{1'b0}};
        p_val = shared_port_data_ff;
        p_gpio = {PW{1'b1}};
        // i2c needs both of its pwm channels off
        i2c_own = i2c_enable & ~pwm_enable[`PPWM_PIN_SCL] &
            ~pwm_enable[`PPWM_PIN_SDA];
        if (i2c_own) begin
            p_gpio[`PPWM_PIN_SCL] = 1'b0;
            p_gpio[`PPWM_PIN_SDA] = 1'b0;
            p_own_out[`PPWM_PIN_SCL] = 1'b1;
            p_own_out[`PPWM_PIN_SDA] = 1'b1;
            p_od[`PPWM_PIN_SCL] = 1'b1;
            p_od[`PPWM_PIN_SDA] = 1'b1;
            p_val[`PPWM_PIN_SCL] = i2c_scl_out;
            p_val[`PPWM_PIN_SDA] = i2c_sda_out;
        end
        if (serial_b_tx_enable & ~pwm_enable[`PPWM_PIN_TXD]) begin
            p_gpio[`PPWM_PIN_TXD] = 1'b0;
            p_own_out[`PPWM_PIN_TXD] = 1'b1;
            p_val[`PPWM_PIN_TXD] = serial_b_transmit;
        end
        if (serial_b_rx_enable & ~pwm_enable[`PPWM_PIN_RXD]) begin
            p_gpio[`PPWM_PIN_RXD] = 1'b0;
            p_own_in[`PPWM_PIN_RXD] = 1'b1;
        end
        // pwm applied last so it overrides the lower-priority owners
        for (i = 0; i < PW; i = i + 1) begin
            if (pwm_enable[i]) begin
                p_gpio[i] = 1'b0;
                p_od[i] = 1'b0;
                p_val[i] = pwm_out[i];
                p_own_out[i] = !(i == PW-1 && pwm_shutdown_en);
                p_own_in[i] = (i == PW-1 && pwm_shutdown_en);
            end
        end
        for (i = 0; i < PW; i = i + 1) begin
            if (p_gpio[i]) begin
                nxt_p_oe[i] = shared_port_direction_ff[i];
                nxt_p_out[i] = shared_port_data_ff[i];
            end else if (p_own_in[i]) begin
                // owner reads the pin, so the driver stays off
                nxt_p_oe[i] = 1'b0;
                nxt_p_out[i] = 1'b0;
            end else if (p_od[i]) begin
                // open-drain: enable only while pulling low
                nxt_p_oe[i] = ~p_val[i];
                nxt_p_out[i] = 1'b0;
            end else begin
                nxt_p_oe[i] = p_own_out[i];
                nxt_p_out[i] = p_val[i];
            end
        end
    end

    // can-port ownership, drive and pulls
    reg [MW-1:0] m_dir;
    reg [MW-1:0] m_val;
    reg [MW-1:0] m_can;
    reg [MW-1:0] nxt_m_out;
    reg [MW-1:0] nxt_m_oe;
    reg [MW-1:0] nxt_m_pu;
    reg [MW-1:0] nxt_m_pd;
    reg pull;
    integer k;
    always @* begin
        m_dir = can_port_direction_ff;
        m_val = can_port_data_ff;
        m_can = {MW{1'b0}};
        for (k = 0; k < 2; k = k + 1) begin
            // an enabled controller overrides the direction bits
            if (can_enable[k]) begin
                m_can[2*k+3] = 1'b1;
                m_can[2*k+2] = 1'b1;
                m_dir[2*k+3] = 1'b1;
                m_dir[2*k+2] = 1'b0;
                m_val[2*k+3] = can_transmit[k];
            end
        end
        for (k = 0; k < MW; k = k + 1) begin
            if (!m_dir[k]) begin
                nxt_m_oe[k] = 1'b0;
                nxt_m_out[k] = 1'b0;
            end else if (can_port_open_drain_select_ff[k]) begin
                nxt_m_oe[k] = ~m_val[k];
                nxt_m_out[k] = 1'b0;
            end else begin
                nxt_m_oe[k] = 1'b1;
                nxt_m_out[k] = m_val[k];
            end
            pull = can_port_pull_enable_ff[k] &
                (~m_dir[k] | can_port_open_drain_select_ff[k]);
            // polarity only for inputs; can pins pull up only
            if (m_can[k]) begin
                nxt_m_pu[k] = pull;
                nxt_m_pd[k] = 1'b0;
            end else if (!m_dir[k]) begin
                nxt_m_pu[k] = pull & ~can_port_pull_polarity_ff[k];
                nxt_m_pd[k] = pull & can_port_pull_polarity_ff[k];
            end else begin
                // open-drain output: no polarity choice, pull-up only
                nxt_m_pu[k] = pull;
                nxt_m_pd[k] = 1'b0;
            end
        end
    end

    // read mux
    reg [31:0] nxt_prdata;
    reg [MW-1:0] p_rb;
    reg [MW-1:0] m_rb;
    always @* begin
        nxt_prdata = 32'h0000_0000;
        // shared port widened so one helper serves both ports
        p_rb = read_back({{(MW-PW){1'b0}}, shared_port_direction_ff},
            {{(MW-PW){1'b0}}, shared_port_data_ff},
            {{(MW-PW){1'b0}}, shared_port_pin_in});
        m_rb = read_back(can_port_direction_ff, can_port_data_ff,
            can_port_pin_in);
        case (paddr)
            `PPWM_OFF_DATA: nxt_prdata[PW-1:0] = p_rb[PW-1:0];
            `PPWM_OFF_LEVELS: nxt_prdata[PW-1:0] = shared_port_pin_in;
            `PPWM_OFF_DIR: nxt_prdata[PW-1:0] = shared_port_direction_ff;
            `PPWM_OFF_CAN_PULL_EN: nxt_prdata[MW-1:0] = can_port_pull_enable_ff;
            `PPWM_OFF_CAN_POL: nxt_prdata[MW-1:0] = can_port_pull_polarity_ff;
            `PPWM_OFF_CAN_OD:
                nxt_prdata[MW-1:0] = can_port_open_drain_select_ff;
            `PPWM_OFF_CAN_DIR: nxt_prdata[MW-1:0] = can_port_direction_ff;
            `PPWM_OFF_CAN_DATA: nxt_prdata[MW-1:0] = m_rb;
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    // configuration registers; a write lands in the first access cycle
    // only, so the answer cycle cannot apply it a second time
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_port_data_ff <= `PPWM_RST_P;
            shared_port_direction_ff <= `PPWM_RST_P;
            can_port_pull_enable_ff <= `PPWM_RST_M;
            can_port_pull_polarity_ff <= `PPWM_RST_M;
            can_port_open_drain_select_ff <= `PPWM_RST_M;
            can_port_direction_ff <= `PPWM_RST_M;
            can_port_data_ff <= `PPWM_RST_M;
        end else begin
            if (wr && !pready) begin
                case (paddr)
                    `PPWM_OFF_DATA: shared_port_data_ff <= pwdata[PW-1:0];
                    `PPWM_OFF_DIR: shared_port_direction_ff <= pwdata[PW-1:0];
                    `PPWM_OFF_CAN_PULL_EN:
                        can_port_pull_enable_ff <= pwdata[MW-1:0];
                    `PPWM_OFF_CAN_POL:
                        can_port_pull_polarity_ff <= pwdata[MW-1:0];
                    `PPWM_OFF_CAN_OD:
                        can_port_open_drain_select_ff <= pwdata[MW-1:0];
                    `PPWM_OFF_CAN_DIR: can_port_direction_ff <= pwdata[MW-1:0];
                    `PPWM_OFF_CAN_DATA: can_port_data_ff <= pwdata[MW-1:0];
                    // levels register keeps no state; its writes land here
                    default: ;
                endcase
            end
        end
    end

    // pin drivers are registered so every output leaves a flip-flop;
    // the price is one clock between an owner change and the pad
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_port_pin_out <= 6'h00;
            shared_port_pin_oe <= 6'h00;
            can_port_pin_out <= 8'h00;
            can_port_pin_oe <= 8'h00;
            can_port_pullup_on <= 8'h00;
            can_port_pulldown_on <= 8'h00;
            serial_b_receive <= 1'b1;
            i2c_scl_in <= 1'b1;
            i2c_sda_in <= 1'b1;
            can_receive <= 2'h3;
        end else begin
            shared_port_pin_out <= nxt_p_out;
            shared_port_pin_oe <= nxt_p_oe;
            can_port_pin_out <= nxt_m_out;
            can_port_pin_oe <= nxt_m_oe;
            can_port_pullup_on <= nxt_m_pu;
            can_port_pulldown_on <= nxt_m_pd;
            // receive copies follow the pads whatever owns the pins
            serial_b_receive <= shared_port_pin_in[`PPWM_PIN_RXD];
            i2c_scl_in <= shared_port_pin_in[`PPWM_PIN_SCL];
            i2c_sda_in <= shared_port_pin_in[`PPWM_PIN_SDA];
            can_receive <= {can_port_pin_in[4], can_port_pin_in[2]};
        end
    end

    // bus response: one wait state, answer in the second access cycle;
    // unmapped offsets answer with pslverr and zero data
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= acc & ~pready;
            pslverr <= acc & ~pready & ~known_addr(paddr);
            prdata <= (acc & ~pready & ~pwrite) ? nxt_prdata : 32'h0000_0000;
        end
    end
endmodule // ppwm_pin_ctrl

// File: hw/ppwm_defs.vh
// register map, field widths and reset values for the port pin-control block
`ifndef PPWM_DEFS_VH
`define PPWM_DEFS_VH
`define PPWM_OFF_DATA 12'h000
`define PPWM_OFF_LEVELS 12'h004
`define PPWM_OFF_DIR 12'h008
`define PPWM_OFF_CAN_PULL_EN 12'h00C
`define PPWM_OFF_CAN_POL 12'h010
`define PPWM_OFF_CAN_OD 12'h014
`define PPWM_OFF_CAN_DIR 12'h018
`define PPWM_OFF_CAN_DATA 12'h01C
`define PPWM_P_WIDTH 6
`define PPWM_M_WIDTH 8
`define PPWM_RST_P 6'h00
`define PPWM_RST_M 8'h00
`define PPWM_PIN_SCL 5
`define PPWM_PIN_SDA 4
`define PPWM_PIN_TXD 0
`define PPWM_PIN_RXD 2
`endif

// File: testbench/ppwm_pin_ctrl_asserts.sv
// concurrent checks on the pin-control block ports
`timescale 1ns/1ps
module ppwm_pin_ctrl_chk (
    // bus
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // shared port
    input wire [5:0] shared_port_pin_out,
    input wire [5:0] shared_port_pin_oe,
    input wire [5:0] pwm_enable,
    input wire [5:0] pwm_out,
    input wire pwm_shutdown_en,
    input wire serial_b_tx_enable,
    input wire serial_b_transmit,
    input wire i2c_enable,
    input wire i2c_scl_out,
    input wire i2c_sda_out,
    // can port
    input wire [1:0] can_enable,
    input wire [7:0] can_port_pin_oe,
    input wire [7:0] can_port_pullup_on,
    input wire [7:0] can_port_pulldown_on
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    access_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    pull_exclusive_a: assert property (
        (can_port_pullup_on & can_port_pulldown_on) == 8'h00)
        else $error("pull-up and pull-down both on");
    can_no_pulldown_a: assert property (
        $past(can_enable[1]) |-> can_port_pulldown_on[5:4] == 2'h0)
        else $error("pull-down on can pins");
    can_rx_input_a: assert property (
        $past(can_enable[1]) |-> !can_port_pin_oe[4])
        else $error("can receive pin driven");
    pwm_force_out_a: assert property (
        ((shared_port_pin_oe[4:0] | ~$past(pwm_enable[4:0])) == 5'h1F) &&
        (((shared_port_pin_out[4:0] ^ $past(pwm_out[4:0]))
        & $past(pwm_enable[4:0])) == 5'h00))
        else $error("pwm pin not forced to output");
    pwm_shutdown_a: assert property (
        $past(pwm_enable[5] && pwm_shutdown_en) |-> !shared_port_pin_oe[5])
        else $error("pwm 5 shutdown pin driven");
    i2c_drain_a: assert property (
        $past(i2c_enable && pwm_enable[5:4] == 2'h0) |->
        shared_port_pin_out[5:4] == 2'h0 &&
        shared_port_pin_oe[5:4] == ~$past({i2c_scl_out, i2c_sda_out}))
        else $error("i2c pins not open-drain");
    serial_tx_a: assert property (
        $past(serial_b_tx_enable && !pwm_enable[0]) |->
        shared_port_pin_oe[0] && shared_port_pin_out[0] ==
        $past(serial_b_transmit))
        else $error("serial transmit pin wrong");
    reset_hiz_a: assert property (
        $rose(presetn) |-> shared_port_pin_oe == 6'h00 &&
        can_port_pin_oe == 8'h00)
        else $error("pins driven out of reset");
    can_a_pins_a: assert property (
        $past(can_enable[0]) |-> !can_port_pin_oe[2] &&
        can_port_pulldown_on[3:2] == 2'h0)
        else $error("can a pins misconfigured");
endmodule // ppwm_pin_ctrl_chk
bind ppwm_pin_ctrl ppwm_pin_ctrl_chk u_chk (.*);

// File: testbench/ppwm_pad_model.sv
// pad model: resolves both ports' pin levels from block and outside drivers
`timescale 1ns/1ps
module ppwm_pad_model (
    // shared port
    input wire [5:0] p_out,
    input wire [5:0] p_oe,
    input wire [5:0] p_ext,
    output wire [5:0] p_in,
    // can port
    input wire [7:0] m_out,
    input wire [7:0] m_oe,
    input wire [7:0] m_ext,
    output wire [7:0] m_in
);
    // released lines show the outside level; i2c lines then sit at whatever p_ext drives, no pull-up is modelled
    assign p_in = (p_oe & p_out) | (~p_oe & p_ext);
    assign m_in = (m_oe & m_out) | (~m_oe & m_ext);
endmodule // ppwm_pad_model

// File: testbench/test_port_pull_wiredor_and_pin_mux.sv
// register and pin-mux tests for the pin-control block
`timescale 1ns/1ps
`include "ppwm_defs.vh"
module test_port_pull_wiredor_and_pin_mux;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [5:0] shared_port_pin_in, shared_port_pin_out, shared_port_pin_oe;
    logic [5:0] pwm_enable = 6'h00, pwm_out = 6'h00, p_ext = 6'h2A;
    logic pwm_shutdown_en = 1'b0, serial_b_tx_enable = 1'b0;
    logic serial_b_rx_enable = 1'b0, serial_b_transmit = 1'b0;
    logic serial_b_receive, i2c_enable = 1'b0, i2c_scl_out = 1'b1;
    logic i2c_sda_out = 1'b1, i2c_scl_in, i2c_sda_in;
    logic [1:0] can_enable = 2'h0, can_transmit = 2'h3, can_receive;
    logic [7:0] can_port_pin_in, can_port_pin_out, can_port_pin_oe;
    logic [7:0] can_port_pullup_on, can_port_pulldown_on, m_ext = 8'h5A;
    int fail_count = 0, compares = 0, cyc = 0;
    always #12.5 pclk = ~pclk;
    ppwm_pin_ctrl DUT (.*);
    ppwm_pad_model u_pad (.p_out(shared_port_pin_out),
        .p_oe(shared_port_pin_oe), .p_ext(p_ext), .p_in(shared_port_pin_in),
        .m_out(can_port_pin_out), .m_oe(can_port_pin_oe), .m_ext(m_ext),
        .m_in(can_port_pin_in));
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", e, rdata);
        chk("pslverr", a > `PPWM_OFF_CAN_DATA, err);
    endtask
    task automatic settle;
        repeat (3) @(posedge pclk);
    endtask
    task automatic wrap_up;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            wrap_up;
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("p_oe", 6'h00, shared_port_pin_oe);
        rd(`PPWM_OFF_DATA, 32'h2A);
        rd(`PPWM_OFF_LEVELS, 32'h2A);
        rd(12'h020, 32'h0);
        wr(`PPWM_OFF_DIR, 32'h3F);
        rd(`PPWM_OFF_DATA, 32'h00);
        $display("test reset done");
        wr(`PPWM_OFF_DATA, 32'hFFFFFFC5);
        wr(`PPWM_OFF_DIR, 32'h0F);
        wr(`PPWM_OFF_LEVELS, 32'h3F);
        settle;
        chk("p_oe", 6'h0F, shared_port_pin_oe);
        chk("p_out", 6'h05, shared_port_pin_out & 6'h0F);
        rd(`PPWM_OFF_DATA, 32'h25);
        rd(`PPWM_OFF_LEVELS, 32'h25);
        rd(`PPWM_OFF_DIR, 32'h0F);
        $display("test gpio done");
        pwm_enable <= 6'h01;
        pwm_out <= 6'h01;
        serial_b_tx_enable <= 1'b1;
        serial_b_rx_enable <= 1'b1;
        settle;
        chk("pin0", 2'h3, {shared_port_pin_oe[0], shared_port_pin_out[0]});
        chk("pin2 oe", 1'b0, shared_port_pin_oe[2]);
        chk("rx", 1'b0, serial_b_receive);
        pwm_enable <= 6'h00;
        settle;
        chk("pin0", 2'h2, {shared_port_pin_oe[0], shared_port_pin_out[0]});
        p_ext <= 6'h3F;
        i2c_enable <= 1'b1;
        i2c_scl_out <= 1'b0;
        settle;
        chk("i2c", 4'h8, {shared_port_pin_oe[5:4], shared_port_pin_out[5:4]});
        chk("scl sda", 2'h1, {i2c_scl_in, i2c_sda_in});
        pwm_enable <= 6'h20;
        pwm_shutdown_en <= 1'b1;
        settle;
        chk("pin5 oe", 1'b0, shared_port_pin_oe[5]);
        pwm_shutdown_en <= 1'b0;
        settle;
        chk("pin5", 2'h2, {shared_port_pin_oe[5], shared_port_pin_out[5]});
        $display("test mux done");
        wr(`PPWM_OFF_CAN_PULL_EN, 32'hFF);
        wr(`PPWM_OFF_CAN_POL, 32'h0F);
        wr(`PPWM_OFF_CAN_DIR, 32'h01);
        settle;
        chk("pd", 8'h0E, can_port_pulldown_on);
        chk("pu", 8'hF0, can_port_pullup_on);
        wr(`PPWM_OFF_CAN_OD, 32'hFF);
        wr(`PPWM_OFF_CAN_DATA, 32'hF0);
        wr(`PPWM_OFF_CAN_DIR, 32'hFF);
        settle;
        chk("m_oe", 8'h0F, can_port_pin_oe);
        chk("m_out", 8'h00, can_port_pin_out);
        chk("pu", 8'hFF, can_port_pullup_on);
        wr(`PPWM_OFF_CAN_OD, 32'h00);
        settle;
        chk("m_oe", 8'hFF, can_port_pin_oe);
        chk("pu", 8'h00, can_port_pullup_on);
        wr(`PPWM_OFF_CAN_OD, 32'h20);
        wr(`PPWM_OFF_CAN_POL, 32'hFF);
        can_enable <= 2'h2;
        can_transmit <= 2'h1;
        settle;
        chk("can", 3'h4, {can_port_pin_oe[5:4], can_port_pin_out[5]});
        chk("can pd", 2'h0, can_port_pulldown_on[5:4]);
        chk("can pu", 2'h3, can_port_pullup_on[5:4]);
        chk("can rx", 1'b1, can_receive[1]);
        rd(`PPWM_OFF_CAN_OD, 32'h20);
        rd(`PPWM_OFF_CAN_POL, 32'hFF);
        rd(`PPWM_OFF_CAN_PULL_EN, 32'hFF);
        can_enable <= 2'h3;
        m_ext <= 8'h04;
        settle;
        chk("can a", 3'h5, {can_port_pin_oe[3:2], can_port_pin_out[3]});
        chk("can a pu", 2'h1, can_port_pullup_on[3:2]);
        chk("can a pd", 2'h0, can_port_pulldown_on[3:2]);
        chk("can rx both", 2'h1, can_receive);
        $display("test can done");
        wrap_up;
    end
endmodule // test_port_pull_wiredor_and_pin_mux
